// *** verilog/acs_adc_ctrl.sv ***
`timescale 1ns/1ps
// Contract
// - the bit time is 2,4,8,16,32 or 64 oscillator periods per codes 000,100,001,101,010,110, and x11 picks the internal rc clock.
// - the internal rc clock gives a bit time of RC_CYCLES system clocks, which is 2.5 us only with the 20 ns clock period.
// - with manual acquisition the start is delayed one instruction cycle so a sleep can follow.
// - the selected pin is sampled whatever its direction, so an output pin converts its driven level.
// - port reads give zero for every pin configured analog.
// - conversions on digital pins are allowed and convert normally.
// - pin assignment is set by the port configuration (i_pin_analog) alone; the direction bits i_pin_direction are not used.
// - at completion the start bit clears, the done flag sets and sampling resumes.
// - a conversion takes 13 bit times.
// - a nonzero acquisition field inserts 2 to 20 bit times between start and conversion.
// - acquisition field 000 is manual and the reset default, converting after the one instruction cycle delay.
module acs_adc_ctrl
	import acs_pkg::*;
#(
	parameter int RC_CYCLES = RC_TAD_CYCLES
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [2:0] i_conv_clock_select,
	input wire logic [2:0] i_acq_time_select,
	input wire logic [3:0] i_channel_select,
	input wire logic i_adc_on,
	input wire logic i_go_set,
	input wire logic i_done_clear,
	input wire logic [PIN_COUNT-1:0] i_pin_analog,
	input wire logic [PIN_COUNT-1:0] i_pin_direction,
	input wire logic [PIN_COUNT-1:0] i_pin_level,
	input wire logic [PIN_COUNT-1:0] i_pin_out_level,
	input wire logic [CHAN_COUNT-1:0] i_chan_sample,
	output logic o_go,
	output logic o_conversion_done_flag,
	output logic o_sampling,
	output logic o_tad_tick,
	output logic o_sample_bit,
	output logic [PIN_COUNT-1:0] o_port_read
);
	// the divider limit is 12 bits wide
	if (RC_CYCLES < 1 || RC_CYCLES > 4096)
	begin : g_bad_rc_cycles
		$error("RC_CYCLES must lie between 1 and 4096");
	end

	// ----------------------------------------
	// bit time generator
	// ----------------------------------------
	logic [11:0] div_reg, div_next;
	logic [11:0] div_limit;
	logic tick_reg, tick_next;

	always_comb
	begin
		case (i_conv_clock_select)
			CS_DIV2: div_limit = 12'h001;
			CS_DIV4: div_limit = 12'h003;
			CS_DIV8: div_limit = 12'h007;
			CS_DIV16: div_limit = 12'h00F;
			CS_DIV32: div_limit = 12'h01F;
			CS_DIV64: div_limit = 12'h03F;
			default: div_limit = 12'(RC_CYCLES - 1);
		endcase
	end

	always_comb
	begin
		tick_next = 1'b0;
		div_next = div_reg + 12'h001;
		if (i_reset || div_reg >= div_limit)
		begin
			div_next = 12'h000;
			tick_next = !i_reset;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		div_reg <= div_next;
		tick_reg <= tick_next;
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	acs_state_t st_reg, st_next;
	logic [4:0] cnt_reg, cnt_next;
	logic go_reg, go_next;
	logic done_reg, done_next;
	logic [4:0] acq_tads;

	// acquisition 001..111 spread over 2..20 bit times
	always_comb
	begin
		case (i_acq_time_select)
			3'h1: acq_tads = 5'h02;
			3'h2: acq_tads = 5'h04;
			3'h3: acq_tads = 5'h06;
			3'h4: acq_tads = 5'h08;
			3'h5: acq_tads = 5'h0C;
			3'h6: acq_tads = 5'h10;
			default: acq_tads = 5'h14;
		endcase
	end

	always_comb
	begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		go_next = go_reg;
		done_next = done_reg;
		if (i_done_clear)
			done_next = 1'b0;
		case (st_reg)
			ST_IDLE:
			begin
				if (i_go_set && i_adc_on)
				begin
					go_next = 1'b1;
					if (i_acq_time_select == ACQ_MANUAL)
					begin
						// one instruction cycle lets a sleep instruction run
						st_next = ST_DELAY;
						cnt_next = 5'(INSTR_CYCLE_CLKS - 1);
					end
					else
					begin
						st_next = ST_ACQ;
						cnt_next = acq_tads - 5'h01;
					end
				end
			end
			ST_DELAY:
			begin
				if (cnt_reg == 5'h00)
				begin
					st_next = ST_CONV;
					cnt_next = 5'(CONV_TADS - 1);
				end
				else
					cnt_next = cnt_reg - 5'h01;
			end
			ST_ACQ:
			begin
				if (tick_reg)
				begin
					if (cnt_reg == 5'h00)
					begin
						st_next = ST_CONV;
						cnt_next = 5'(CONV_TADS - 1);
					end
					else
						cnt_next = cnt_reg - 5'h01;
				end
			end
			ST_CONV:
			begin
				if (tick_reg)
				begin
					if (cnt_reg == 5'h00)
					begin
						st_next = ST_IDLE;
						go_next = 1'b0;
						done_next = 1'b1;
					end
					else
						cnt_next = cnt_reg - 5'h01;
				end
			end
			default: st_next = ST_IDLE;
		endcase
		// turning the module off aborts a conversion
		if (!i_adc_on && st_reg != ST_IDLE)
		begin
			st_next = ST_IDLE;
			go_next = 1'b0;
		end
		if (i_reset)
		begin
			st_next = ST_IDLE;
			cnt_next = 5'h00;
			go_next = 1'b0;
			done_next = 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		st_reg <= st_next;
		cnt_reg <= cnt_next;
		go_reg <= go_next;
		done_reg <= done_next;
	end

	// ----------------------------------------
	// pins
	// ----------------------------------------
	logic [PIN_COUNT-1:0] rd_reg, rd_next;
	logic samp_reg, samp_next;
	logic bit_reg, bit_next;
	logic [CHAN_COUNT-1:0] chan_sel;

	always_comb
	begin
		chan_sel = '0;
		if (i_channel_select < 4'(CHAN_COUNT))
			chan_sel[i_channel_select] = 1'b1;
		// analog pins read low; pin map from i_pin_analog only, port directions unused
		rd_next = i_pin_level & ~i_pin_analog;
		// sampled regardless of direction or digital setting
		samp_next = (st_next != ST_CONV) && (st_next != ST_DELAY);
		bit_next = |(i_chan_sample & chan_sel);
		if (i_reset)
		begin
			rd_next = '0;
			samp_next = 1'b1;
			bit_next = 1'b0;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		rd_reg <= rd_next;
		samp_reg <= samp_next;
		bit_reg <= bit_next;
	end

	assign o_go = go_reg;
	assign o_conversion_done_flag = done_reg;
	assign o_sampling = samp_reg;
	assign o_tad_tick = tick_reg;
	assign o_sample_bit = bit_reg;
	assign o_port_read = rd_reg;
endmodule // acs_adc_ctrl

// *** verilog/acs_pkg.sv ***
package acs_pkg;
	// ----------------------------------------
	// timing and sizes
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int RC_TAD_NS = 2500;
	localparam int RC_TAD_CYCLES = (RC_TAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_TADS = 13;
	localparam int INSTR_CYCLE_CLKS = 4;
	localparam int PIN_COUNT = 24;
	localparam int CHAN_COUNT = 12;
	localparam int RESULT_BITS = 12;
	// ----------------------------------------
	// field codes and reset values
	// ----------------------------------------
	localparam logic [2:0] CS_DIV2 = 3'h0;
	localparam logic [2:0] CS_DIV4 = 3'h4;
	localparam logic [2:0] CS_DIV8 = 3'h1;
	localparam logic [2:0] CS_DIV16 = 3'h5;
	localparam logic [2:0] CS_DIV32 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h6;
	localparam logic [2:0] ACQ_MANUAL = 3'h0;
	localparam logic [2:0] ACQ_RESET = 3'h0;
	typedef enum {ST_IDLE, ST_DELAY, ST_ACQ, ST_CONV} acs_state_t;
endpackage

// *** verif/acs_adc_ctrl_monitor.sv ***
`timescale 1ns/1ps
module acs_adc_ctrl_monitor
	import acs_pkg::*;
#(
	parameter int RC_CYCLES = RC_TAD_CYCLES
)
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [2:0] i_conv_clock_select,
	input wire logic [2:0] i_acq_time_select,
	input wire logic i_adc_on,
	input wire logic i_go_set,
	input wire logic i_done_clear,
	input wire logic [PIN_COUNT-1:0] i_pin_analog,
	input wire logic [PIN_COUNT-1:0] i_pin_level,
	input wire logic o_go,
	input wire logic o_conversion_done_flag,
	input wire logic o_sampling,
	input wire logic o_tad_tick,
	input wire logic [PIN_COUNT-1:0] o_port_read
);
	// ----
	// checks
	// ----
	wire logic tk = i_go_set && i_adc_on && !o_go;
	wire logic man = i_acq_time_select == ACQ_MANUAL;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	AST_START: assert property (tk |=> o_go) else $error("start");
	AST_MANUAL: assert property (tk && man |=> (o_go && !o_sampling) [*5]) else $error("manual");
	AST_AUTO: assert property (tk && !man |=> (o_go && o_sampling) [*2]) else $error("acq");
	AST_DONE: assert property (!$past(i_reset) && $fell(o_go) && $past(i_adc_on)
		|-> o_conversion_done_flag && o_sampling) else $error("done");
	AST_STICKY: assert property (o_conversion_done_flag && !i_done_clear |=> o_conversion_done_flag)
		else $error("sticky");
	AST_ABORT: assert property (!i_adc_on |=> !o_go) else $error("abort");
	AST_PORT: assert property (!$past(i_reset)
		|-> o_port_read == ($past(i_pin_level) & ~$past(i_pin_analog))) else $error("port");
	AST_TICK: assert property (o_tad_tick && i_conv_clock_select == CS_DIV4 |=> !o_tad_tick [*3])
		else $error("tick");
	cover property (tk && man);
	cover property (tk && !man);
	cover property ($fell(o_go) && o_conversion_done_flag);
endmodule // acs_adc_ctrl_monitor
bind acs_adc_ctrl acs_adc_ctrl_monitor #(.RC_CYCLES(RC_CYCLES)) i_acs_mon (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_conv_clock_select(i_conv_clock_select), .i_acq_time_select(i_acq_time_select), .i_adc_on(i_adc_on),
	.i_go_set(i_go_set), .i_done_clear(i_done_clear), .i_pin_analog(i_pin_analog), .i_pin_level(i_pin_level),
	.o_go(o_go), .o_conversion_done_flag(o_conversion_done_flag), .o_sampling(o_sampling),
	.o_tad_tick(o_tad_tick), .o_port_read(o_port_read));

// *** verif/acs_adc_ctrl_bench.sv ***
`timescale 1ns/1ps
module acs_adc_ctrl_bench;
	import acs_pkg::*;
	logic c = 1'b0, r = 1'b1, on = 1'b1, gs = 1'b0, dc = 1'b0, go, df, sa, tk, sb;
	logic [2:0] cs = 3'h0, aq = 3'h0;
	logic [3:0] ch = 4'h0;
	logic [23:0] an = 24'h0, lv = 24'h0, pr;
	logic [11:0] sm = 12'h0;
	int failures = 0, checked = 0, cyc = 0;
	// model: bit time in clocks per code, acquisition bit times per code
	int dv[8] = '{2, 8, 32, 2, 4, 16, 64, 2};
	int at[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	acs_adc_ctrl #(.RC_CYCLES(2)) i_acs_adc_ctrl (.i_mclk(c), .i_reset(r), .i_conv_clock_select(cs),
		.i_acq_time_select(aq), .i_channel_select(ch), .i_adc_on(on), .i_go_set(gs), .i_done_clear(dc),
		.i_pin_analog(an), .i_pin_direction(an), .i_pin_level(lv), .i_pin_out_level(lv),
		.i_chan_sample(sm), .o_go(go), .o_conversion_done_flag(df), .o_sampling(sa), .o_tad_tick(tk),
		.o_sample_bit(sb), .o_port_read(pr));
	initial forever #10 c = ~c;
	always @(posedge c)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			close_out();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", n, e, s);
		end
	endtask
	task automatic close_out();
		if (failures == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ----
	// one conversion, pins randomised at its start
	// ----
	task automatic conv(input int k, input int a);
		int t, l = 0, p = 0, n = 0;
		an = 24'($urandom);
		lv = 24'($urandom);
		sm = 12'($urandom);
		ch = 4'($urandom % 12);
		cs = 3'(k);
		aq = 3'(a);
		gs = 1'b1;
		@(negedge c);
		gs = 1'b0;
		chk("port", pr, lv & ~an);
		chk("sample", sb, sm[ch]);
		chk("start", {go, sa}, {1'b1, a != 0});
		for (t = 1; t < 3000 && go; t++)
		begin
			if (tk)
			begin
				p = t - l;
				l = t;
				n++;
			end
			@(negedge c);
		end
		chk("period", p, dv[k]);
		chk("ticks", n >= at[a] + 13 && n <= at[a] + 15, 1);
		chk("done", {go, df, sa}, 3'h3);
		dc = 1'b1;
		@(negedge c);
		dc = 1'b0;
		@(negedge c);
		chk("clear", df, 0);
	endtask
	initial
	begin
		void'($urandom(6));
		repeat (10) @(negedge c);
		r = 1'b0;
		@(negedge c);
		chk("reset", {go, df, sa, pr}, 27'h1000000);
		for (int i = 0; i < 8; i++)
			conv(i, 7 - i);
		gs = 1'b1;
		@(negedge c);
		gs = 1'b0;
		// drop enable only once the conversion itself runs
		repeat (5) @(negedge c);
		chk("busy", {go, sa}, 2'h2);
		on = 1'b0;
		repeat (2) @(negedge c);
		chk("abort", {go, df}, 0);
		gs = 1'b1;
		@(negedge c);
		gs = 1'b0;
		chk("refused", go, 0);
		close_out();
	end
endmodule // acs_adc_ctrl_bench
